// file: enclave_page_augment_pkg.sv
// Constants, types and functional notes for the page-augment sequencer
// Functional notes
// - Execute only at privilege level zero
// - Descriptor not 32-byte aligned gives GP
// - Destination not 4K aligned gives GP
// - Destination outside page cache gives PF
// - Nonzero security pointer must be 64-byte aligned
// - Control page or target address unaligned: GP
// - Nonzero source page pointer gives GP
// - Control page outside page cache gives PF
// - Busy destination: conflict exit or GP
// - Destination map entry already valid gives PF
// - Zero pointer selects regular read-write defaults
// - Bad supplied security block gives GP
// - Shadow-stack type without enforcement enable: GP
// - Control page shared access conflict gives GP
// - Invalid or wrong-type control page gives PF
// - Uninitialized enclave gives GP
// - Target outside enclave range gives GP
// - Shadow-stack page on range edges gives GP
// - Zero the whole destination page
// - Shadow-stack first page gets restore token
// - Fill map entry pending, valid set last
package enclave_page_augment_pkg;

	// ----------------------------------------------------------------
	// Leaf selection and privilege
	// ----------------------------------------------------------------
	localparam logic [31:0] LEAF_AUGMENT = 32'h0000000d;
	localparam logic [1:0] CPL_KERNEL = 2'h0;

	// ----------------------------------------------------------------
	// Alignment masks and page geometry
	// ----------------------------------------------------------------
	localparam logic [63:0] DESC_ALIGN_MASK = 64'h000000000000001f;
	localparam logic [63:0] SECURITY_INFO_BLOCK_ALIGN_MASK = 64'h000000000000003f;
	localparam logic [63:0] PAGE_ALIGN_MASK = 64'h0000000000000fff;
	localparam logic [63:0] PAGE_SIZE = 64'h0000000000001000;
	localparam logic [63:0] TOKEN_OFFSET = 64'h0000000000000ff8;
	localparam logic [63:0] WORD_BYTES = 64'h0000000000000008;
	localparam int IDX_W = 9;
	localparam logic [IDX_W-1:0] LAST_WORD = 9'h1ff;

	// ----------------------------------------------------------------
	// Page type encodings
	// ----------------------------------------------------------------
	localparam logic [7:0] REGULAR_PAGE_TYPE = 8'h01;
	localparam logic [7:0] CONTROL_PAGE_TYPE = 8'h00;
	localparam logic [7:0] SHADOW_STACK_FIRST_TYPE = 8'h05;
	localparam logic [7:0] SHADOW_STACK_REST_TYPE = 8'h06;

	// ----------------------------------------------------------------
	// Conflict exit coding
	// ----------------------------------------------------------------
	localparam logic [15:0] PAGE_CONFLICT_EXIT_REASON = 16'h0040;
	localparam logic [15:0] TARGET_CONFLICT_QUALIFICATION = 16'h0001;
	localparam logic [15:0] CONFLICT_ERROR_NONE = 16'h0000;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [63:0] source_page_pointer;
		logic [63:0] ctrl_page;
		logic [63:0] sec_info;
		logic [63:0] target_linear_address;
	} page_info_descriptor_t;

	typedef struct packed {
		logic [7:0] ptype;
		logic r;
		logic w;
		logic x;
		logic reserved_nz;
	} security_info_block_t;

	typedef struct packed {
		logic resolves;
		logic shared_busy;
		logic map_valid;
		logic [7:0] map_type;
		logic initialized;
		logic [63:0] enclave_base;
		logic [63:0] size;
		logic wide_mode_attribute;
		logic [63:0] ident;
	} ctrl_page_state_t;

	typedef struct packed {
		logic resolves;
		logic excl_busy;
		logic map_valid;
		logic [63:0] guest_phys;
	} dest_state_t;

	typedef struct packed {
		logic [1:0] cpl;
		logic ss_types_supported;
		logic control_flow_enforce_enable;
		logic shadow_stack_feature_bit;
		logic guest_execution_mode;
		logic virt_ext_enable;
	} env_t;

	typedef struct packed {
		logic r;
		logic w;
		logic x;
		logic [7:0] ptype;
		logic [63:0] enclave_addr;
		logic blocked;
		logic pending;
		logic modified;
		logic permission_restrict_flag;
		logic [63:0] ctrl_id;
		logic valid;
	} map_entry_t;

	typedef struct packed {
		logic [15:0] reason;
		logic [15:0] qual_code;
		logic [15:0] qual_error;
		logic [63:0] guest_phys;
		logic [63:0] guest_lin;
	} exit_info_t;

	typedef enum logic [2:0] {
		FAULT_NONE = 3'h0,
		FAULT_GP = 3'h1,
		FAULT_PF_DEST = 3'h2,
		FAULT_PF_CTRL = 3'h3,
		FAULT_VMEXIT = 3'h4
	} fault_t;

endpackage

// file: augment_check.sv
// Ordered fault checks and attribute choice for one page-augment request
`timescale 1ns/10ps
module augment_check (
	// Operands
	input wire logic [63:0] i_desc_ptr,
	input wire logic [63:0] i_dest_ptr,
	input wire enclave_page_augment_pkg::page_info_descriptor_t i_desc,
	input wire enclave_page_augment_pkg::security_info_block_t i_sec,
	// Machine state
	input wire enclave_page_augment_pkg::ctrl_page_state_t i_ctrl,
	input wire enclave_page_augment_pkg::dest_state_t i_dest,
	input wire enclave_page_augment_pkg::env_t i_env,
	// Verdict
	output enclave_page_augment_pkg::fault_t o_fault,
	output enclave_page_augment_pkg::security_info_block_t o_attr
);

	function automatic logic misaligned(input logic [63:0] addr, input logic [63:0] mask);
		misaligned = (addr & mask) != 64'h0;
	endfunction

	function automatic logic is_ss(input logic [7:0] t);
		is_ss = (t == enclave_page_augment_pkg::SHADOW_STACK_FIRST_TYPE) ||
			(t == enclave_page_augment_pkg::SHADOW_STACK_REST_TYPE);
	endfunction

	logic sec_zero;
	logic [64:0] range_end;
	logic [63:0] last_page;

	// Range end kept one bit wider to avoid a wrap at the top
	assign sec_zero = i_desc.sec_info == 64'h0;
	assign range_end = {1'b0, i_ctrl.enclave_base} + {1'b0, i_ctrl.size};
	assign last_page = i_ctrl.enclave_base + i_ctrl.size - enclave_page_augment_pkg::PAGE_SIZE;

	// Attribute selection: defaults or the supplied block
	always_comb begin
		if (sec_zero) begin
			o_attr = '0;
			o_attr.ptype = enclave_page_augment_pkg::REGULAR_PAGE_TYPE;
			o_attr.r = 1'b1;
			o_attr.w = 1'b1;
			o_attr.x = 1'b0;
		end else begin
			o_attr = i_sec;
		end
	end

	// Priority chain, first failing check decides
	always_comb begin
		o_fault = enclave_page_augment_pkg::FAULT_NONE;
		if (misaligned(i_desc_ptr, enclave_page_augment_pkg::DESC_ALIGN_MASK)) begin
			o_fault = enclave_page_augment_pkg::FAULT_GP;
		end else if (misaligned(i_dest_ptr, enclave_page_augment_pkg::PAGE_ALIGN_MASK)) begin
			o_fault = enclave_page_augment_pkg::FAULT_GP;
		end else if (!i_dest.resolves) begin
			o_fault = enclave_page_augment_pkg::FAULT_PF_DEST;
		end else if (!sec_zero &&
			misaligned(i_desc.sec_info, enclave_page_augment_pkg::SECURITY_INFO_BLOCK_ALIGN_MASK)) begin
			o_fault = enclave_page_augment_pkg::FAULT_GP;
		end else if (misaligned(i_desc.ctrl_page, enclave_page_augment_pkg::PAGE_ALIGN_MASK) ||
			misaligned(i_desc.target_linear_address,
			enclave_page_augment_pkg::PAGE_ALIGN_MASK)) begin
			o_fault = enclave_page_augment_pkg::FAULT_GP;
		end else if (i_desc.source_page_pointer != 64'h0) begin
			o_fault = enclave_page_augment_pkg::FAULT_GP;
		end else if (!i_ctrl.resolves) begin
			o_fault = enclave_page_augment_pkg::FAULT_PF_CTRL;
		end else if (i_dest.excl_busy) begin
			if (i_env.guest_execution_mode && i_env.virt_ext_enable) begin
				o_fault = enclave_page_augment_pkg::FAULT_VMEXIT;
			end else begin
				o_fault = enclave_page_augment_pkg::FAULT_GP;
			end
		end else if (i_dest.map_valid) begin
			o_fault = enclave_page_augment_pkg::FAULT_PF_DEST;
		end else if (!sec_zero && (i_sec.reserved_nz || !i_env.ss_types_supported ||
			!is_ss(i_sec.ptype) || !i_sec.r || !i_sec.w || i_sec.x)) begin
			o_fault = enclave_page_augment_pkg::FAULT_GP;
		end else if (is_ss(o_attr.ptype) && !i_env.control_flow_enforce_enable) begin
			o_fault = enclave_page_augment_pkg::FAULT_GP;
		end else if (i_ctrl.shared_busy) begin
			o_fault = enclave_page_augment_pkg::FAULT_GP;
		end else if (!i_ctrl.map_valid ||
			i_ctrl.map_type != enclave_page_augment_pkg::CONTROL_PAGE_TYPE) begin
			o_fault = enclave_page_augment_pkg::FAULT_PF_CTRL;
		end else if (!i_ctrl.initialized) begin
			o_fault = enclave_page_augment_pkg::FAULT_GP;
		end else if (i_desc.target_linear_address < i_ctrl.enclave_base ||
			{1'b0, i_desc.target_linear_address} >= range_end) begin
			o_fault = enclave_page_augment_pkg::FAULT_GP;
		end else if (is_ss(o_attr.ptype) &&
			(i_desc.target_linear_address == i_ctrl.enclave_base ||
			i_desc.target_linear_address == last_page)) begin
			o_fault = enclave_page_augment_pkg::FAULT_GP;
		end
	end

endmodule

// file: page_zero_writer.sv
// Word writer that clears a page and optionally places a restore token
`timescale 1ns/10ps
module page_zero_writer (
	// Clock and reset
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	// Control
	input wire logic i_go,
	input wire logic i_token_en,
	input wire logic [63:0] i_token_data,
	input wire logic [63:0] i_page,
	// Memory write port
	input wire logic i_mem_ready,
	output logic o_we,
	output logic [63:0] o_addr,
	output logic [63:0] o_data,
	output logic o_finish
);

	logic [enclave_page_augment_pkg::IDX_W-1:0] idx;
	logic [enclave_page_augment_pkg::IDX_W-1:0] next_idx;
	logic in_tok;
	logic next_in_tok;
	logic tok_pend;
	logic next_tok_pend;
	logic next_we;
	logic [63:0] next_addr;
	logic [63:0] next_data;
	logic next_finish;
	logic [9:0] zero_cnt;

	// Next write; a word is taken when we and ready meet at an edge
	always_comb begin
		next_idx = idx;
		next_in_tok = in_tok;
		next_tok_pend = tok_pend;
		next_we = o_we;
		next_addr = o_addr;
		next_data = o_data;
		next_finish = 1'b0;
		if (!o_we && i_go) begin
			next_we = 1'b1;
			next_addr = i_page;
			next_data = 64'h0;
			next_idx = '0;
			next_in_tok = 1'b0;
			next_tok_pend = i_token_en;
		end else if (o_we && i_mem_ready) begin
			if (!in_tok && idx != enclave_page_augment_pkg::LAST_WORD) begin
				next_idx = idx + 1'b1;
				next_addr = o_addr + enclave_page_augment_pkg::WORD_BYTES;
			end else if (!in_tok && tok_pend) begin
				// Token goes after the clear so the zero pass cannot overwrite it
				next_in_tok = 1'b1;
				next_tok_pend = 1'b0;
				next_addr = i_page + enclave_page_augment_pkg::TOKEN_OFFSET;
				next_data = i_token_data;
			end else begin
				next_we = 1'b0;
				next_in_tok = 1'b0;
				next_finish = 1'b1;
			end
		end
	end

	// State registers
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			idx <= '0;
			in_tok <= 1'b0;
			tok_pend <= 1'b0;
			o_we <= 1'b0;
			o_addr <= 64'h0;
			o_data <= 64'h0;
			o_finish <= 1'b0;
		end else begin
			idx <= next_idx;
			in_tok <= next_in_tok;
			tok_pend <= next_tok_pend;
			o_we <= next_we;
			o_addr <= next_addr;
			o_data <= next_data;
			o_finish <= next_finish;
		end
	end

	// Helper count of accepted zero words, only read by a check
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			zero_cnt <= 10'h000;
		end else if (!o_we && i_go) begin
			zero_cnt <= 10'h000;
		end else if (o_we && i_mem_ready && !in_tok && o_data == 64'h0) begin
			zero_cnt <= zero_cnt + 10'h001;
		end
	end

	zero_data_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		(o_we && !in_tok) |-> o_data == 64'h0)
		else $error("clear write carries nonzero data");

	full_page_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		o_finish |-> zero_cnt == 10'h200)
		else $error("page finished without 512 zero words");

	token_place_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		(o_we && in_tok) |-> o_addr == i_page + enclave_page_augment_pkg::TOKEN_OFFSET)
		else $error("restore token written at wrong offset");

endmodule

// file: enclave_page_augment.sv
// Sequencer for the leaf that adds a pending page to an initialized enclave
`timescale 1ns/10ps
module enclave_page_augment (
	// Clock and reset
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	// Leaf request
	input wire logic i_start,
	input wire logic [31:0] i_leaf_select,
	input wire logic [63:0] i_desc_ptr,
	input wire logic [63:0] i_dest_ptr,
	input wire enclave_page_augment_pkg::page_info_descriptor_t i_desc,
	input wire enclave_page_augment_pkg::security_info_block_t i_sec,
	// Machine state
	input wire enclave_page_augment_pkg::ctrl_page_state_t i_ctrl,
	input wire enclave_page_augment_pkg::dest_state_t i_dest,
	input wire enclave_page_augment_pkg::env_t i_env,
	// Completion
	output logic o_busy,
	output logic o_refused,
	output logic o_done,
	output enclave_page_augment_pkg::fault_t o_fault,
	output logic [63:0] o_pf_addr,
	output enclave_page_augment_pkg::exit_info_t o_exit,
	// Page memory write port
	input wire logic i_mem_ready,
	output logic o_mem_we,
	output logic [63:0] o_mem_addr,
	output logic [63:0] o_mem_data,
	// Page map write port
	output logic o_map_we,
	output logic [63:0] o_map_addr,
	output enclave_page_augment_pkg::map_entry_t o_map_entry
);

	// ----------------------------------------------------------------
	// States
	// ----------------------------------------------------------------
	typedef enum logic [4:0] {
		ST_IDLE = 5'h01,
		ST_CHECK = 5'h02,
		ST_CLEAR = 5'h04,
		ST_MAP = 5'h08,
		ST_SEAL = 5'h10
	} state_t;

	state_t state;
	state_t next_state;

	// ----------------------------------------------------------------
	// Captured operands and results
	// ----------------------------------------------------------------
	logic [63:0] dest;
	logic [63:0] next_dest;
	enclave_page_augment_pkg::security_info_block_t attr;
	enclave_page_augment_pkg::security_info_block_t next_attr;
	logic [63:0] lin;
	logic [63:0] next_lin;
	logic [63:0] ctrl_id;
	logic [63:0] next_ctrl_id;
	logic [63:0] tok;
	logic [63:0] next_tok;
	logic tok_en;
	logic next_tok_en;
	logic go;
	logic next_go;
	logic next_busy;
	logic next_refused;
	logic next_done;
	enclave_page_augment_pkg::fault_t next_fault;
	logic [63:0] next_pf_addr;
	enclave_page_augment_pkg::exit_info_t next_exit;
	logic next_map_we;
	enclave_page_augment_pkg::map_entry_t next_map_entry;

	enclave_page_augment_pkg::fault_t chk_fault;
	enclave_page_augment_pkg::security_info_block_t chk_attr;
	logic wr_finish;
	logic leaf_hit;

	// Software picks this leaf through the select value
	assign leaf_hit = i_start && (i_leaf_select == enclave_page_augment_pkg::LEAF_AUGMENT);

	// ----------------------------------------------------------------
	// Ordered checks
	// ----------------------------------------------------------------
	augment_check u_check (
		.i_desc_ptr(i_desc_ptr),
		.i_dest_ptr(i_dest_ptr),
		.i_desc(i_desc),
		.i_sec(i_sec),
		.i_ctrl(i_ctrl),
		.i_dest(i_dest),
		.i_env(i_env),
		.o_fault(chk_fault),
		.o_attr(chk_attr)
	);

	// ----------------------------------------------------------------
	// Page clear and token writer
	// ----------------------------------------------------------------
	page_zero_writer u_writer (
		.i_clk_sys(i_clk_sys),
		.i_rst_n(i_rst_n),
		.i_go(go),
		.i_token_en(tok_en),
		.i_token_data(tok),
		.i_page(dest),
		.i_mem_ready(i_mem_ready),
		.o_we(o_mem_we),
		.o_addr(o_mem_addr),
		.o_data(o_mem_data),
		.o_finish(wr_finish)
	);

	assign o_map_addr = dest;

	// Sequencer next state; operands must hold while busy
	always_comb begin
		next_state = state;
		next_dest = dest;
		next_attr = attr;
		next_lin = lin;
		next_ctrl_id = ctrl_id;
		next_tok = tok;
		next_tok_en = tok_en;
		next_go = 1'b0;
		next_refused = 1'b0;
		next_done = 1'b0;
		next_fault = o_fault;
		next_pf_addr = o_pf_addr;
		next_exit = o_exit;
		next_map_we = 1'b0;
		next_map_entry = o_map_entry;
		unique case (state)
			ST_IDLE: begin
				if (leaf_hit) begin
					if (i_env.cpl != enclave_page_augment_pkg::CPL_KERNEL) begin
						next_refused = 1'b1;
					end else begin
						next_state = ST_CHECK;
						next_dest = i_dest_ptr;
					end
				end
			end
			ST_CHECK: begin
				next_fault = chk_fault;
				next_attr = chk_attr;
				next_lin = i_desc.target_linear_address;
				next_ctrl_id = i_ctrl.ident;
				// Token value prepared now, written only after the clear
				next_tok = (i_desc.target_linear_address + enclave_page_augment_pkg::PAGE_SIZE) |
					{63'h0, i_ctrl.wide_mode_attribute};
				next_tok_en = i_env.shadow_stack_feature_bit &&
					(chk_attr.ptype == enclave_page_augment_pkg::SHADOW_STACK_FIRST_TYPE);
				next_pf_addr = (chk_fault == enclave_page_augment_pkg::FAULT_PF_CTRL) ?
					i_desc.ctrl_page : dest;
				next_exit = '0;
				if (chk_fault == enclave_page_augment_pkg::FAULT_VMEXIT) begin
					next_exit.reason = enclave_page_augment_pkg::PAGE_CONFLICT_EXIT_REASON;
					next_exit.qual_code = enclave_page_augment_pkg::TARGET_CONFLICT_QUALIFICATION;
					next_exit.qual_error = enclave_page_augment_pkg::CONFLICT_ERROR_NONE;
					next_exit.guest_phys = i_dest.guest_phys;
					next_exit.guest_lin = dest;
				end
				if (chk_fault != enclave_page_augment_pkg::FAULT_NONE) begin
					// Fault ends here, before any write reaches page or map
					next_done = 1'b1;
					next_state = ST_IDLE;
				end else begin
					next_go = 1'b1;
					next_state = ST_CLEAR;
				end
			end
			ST_CLEAR: begin
				if (wr_finish) begin
					// Entry written first with valid clear
					next_map_we = 1'b1;
					next_map_entry.r = attr.r;
					next_map_entry.w = attr.w;
					next_map_entry.x = attr.x;
					next_map_entry.ptype = attr.ptype;
					next_map_entry.enclave_addr = lin;
					next_map_entry.blocked = 1'b0;
					next_map_entry.pending = 1'b1;
					next_map_entry.modified = 1'b0;
					next_map_entry.permission_restrict_flag = 1'b0;
					next_map_entry.ctrl_id = ctrl_id;
					next_map_entry.valid = 1'b0;
					next_state = ST_MAP;
				end
			end
			ST_MAP: begin
				// Valid raised by a separate, final write
				next_map_we = 1'b1;
				next_map_entry.valid = 1'b1;
				next_state = ST_SEAL;
			end
			ST_SEAL: begin
				next_done = 1'b1;
				next_state = ST_IDLE;
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
		next_busy = next_state != ST_IDLE;
	end

	// Sequencer registers
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state <= ST_IDLE;
			dest <= 64'h0;
			attr <= '0;
			lin <= 64'h0;
			ctrl_id <= 64'h0;
			tok <= 64'h0;
			tok_en <= 1'b0;
			go <= 1'b0;
			o_busy <= 1'b0;
			o_refused <= 1'b0;
			o_done <= 1'b0;
			o_fault <= enclave_page_augment_pkg::FAULT_NONE;
			o_pf_addr <= 64'h0;
			o_exit <= '0;
			o_map_we <= 1'b0;
			o_map_entry <= '0;
		end else begin
			state <= next_state;
			dest <= next_dest;
			attr <= next_attr;
			lin <= next_lin;
			ctrl_id <= next_ctrl_id;
			tok <= next_tok;
			tok_en <= next_tok_en;
			go <= next_go;
			o_busy <= next_busy;
			o_refused <= next_refused;
			o_done <= next_done;
			o_fault <= next_fault;
			o_pf_addr <= next_pf_addr;
			o_exit <= next_exit;
			o_map_we <= next_map_we;
			o_map_entry <= next_map_entry;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge i_clk_sys);
	endclocking
	default disable iff (!i_rst_n);

	sequence map_pair_s;
		o_map_we && !o_map_entry.valid ##1 o_map_we && o_map_entry.valid;
	endsequence

	sequence fault_report_s;
		o_done && o_fault != enclave_page_augment_pkg::FAULT_NONE && !o_busy;
	endsequence

	priv_refuse_a: assert property (
		(state == ST_IDLE && leaf_hit && i_env.cpl != enclave_page_augment_pkg::CPL_KERNEL)
		|=> o_refused && !o_busy && !o_mem_we)
		else $error("leaf ran outside privilege level zero");

	desc_align_a: assert property (
		(state == ST_CHECK && i_desc_ptr[4:0] != 5'h00)
		|=> o_done && o_fault == enclave_page_augment_pkg::FAULT_GP)
		else $error("misaligned descriptor not faulted");

	fault_quiet_a: assert property (
		(state == ST_CHECK && chk_fault != enclave_page_augment_pkg::FAULT_NONE)
		|=> fault_report_s ##1 (!o_mem_we && !o_map_we) [*2])
		else $error("faulting request touched page or map");

	seal_order_a: assert property (
		(state == ST_CLEAR && wr_finish) |=> map_pair_s ##1 o_done && !o_map_we)
		else $error("map entry not written with valid last");

	entry_pending_a: assert property (
		o_map_we |-> o_map_entry.pending && !o_map_entry.blocked &&
		!o_map_entry.modified && !o_map_entry.permission_restrict_flag &&
		o_map_entry.ctrl_id == ctrl_id && o_map_entry.enclave_addr == lin)
		else $error("map entry fields wrong");

	default_attr_a: assert property (
		(state == ST_CHECK && i_desc.sec_info == 64'h0 &&
		chk_fault == enclave_page_augment_pkg::FAULT_NONE)
		|=> attr.r && attr.w && !attr.x &&
		attr.ptype == enclave_page_augment_pkg::REGULAR_PAGE_TYPE)
		else $error("default attributes not applied");

	conflict_exit_a: assert property (
		(o_done && o_fault == enclave_page_augment_pkg::FAULT_VMEXIT)
		|-> o_exit.qual_error == enclave_page_augment_pkg::CONFLICT_ERROR_NONE &&
		o_exit.guest_lin == dest &&
		o_exit.reason == enclave_page_augment_pkg::PAGE_CONFLICT_EXIT_REASON)
		else $error("conflict exit fields wrong");

	pf_addr_a: assert property (
		(o_done && o_fault == enclave_page_augment_pkg::FAULT_PF_DEST) |-> o_pf_addr == dest)
		else $error("page fault address is not the destination");

	clear_start_a: assert property (
		(state == ST_CHECK && chk_fault == enclave_page_augment_pkg::FAULT_NONE)
		|=> ##1 o_mem_we && o_mem_addr == dest && o_mem_data == 64'h0)
		else $error("page clear did not start at the page base");

endmodule

// file: augment_mem_model.sv
// Page memory partner that accepts writes promptly or with stalls
`timescale 1ns/10ps
module augment_mem_model (
	// Clock and reset
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	// Write port
	input wire logic i_slow,
	input wire logic i_we,
	input wire logic [63:0] i_addr,
	input wire logic [63:0] i_data,
	output logic o_ready,
	// Observed traffic
	output int o_count,
	output int o_nz,
	output logic [63:0] o_last,
	output logic [63:0] o_last_addr
);
	// Stall every other cycle when slow, so held writes get exercised
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_ready <= 1'b0;
			o_count <= 0;
			o_nz <= 0;
			o_last <= 64'h0;
			o_last_addr <= 64'h0;
		end else begin
			o_ready <= i_slow ? ~o_ready : 1'b1;
			if (i_we && o_ready) begin
				o_count <= o_count + 1;
				o_nz <= o_nz + int'(i_data != 64'h0);
				o_last <= i_data;
				o_last_addr <= i_addr;
			end
		end
	end
endmodule

// file: enclave_page_augment_tb_top.sv
// Self-checking bench for the page-augment sequencer
`timescale 1ns/10ps
module enclave_page_augment_tb_top;
	// ----------------------------------------------------------------
	// Stimulus and observed signals
	// ----------------------------------------------------------------
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	logic start = 1'b0;
	logic slow = 1'b0;
	logic [31:0] leaf = 32'h0000000d;
	logic [63:0] desc_ptr, dest_ptr, mem_data, last, pf, mem_addr, map_addr, last_addr;
	enclave_page_augment_pkg::page_info_descriptor_t desc;
	enclave_page_augment_pkg::security_info_block_t sec;
	enclave_page_augment_pkg::ctrl_page_state_t ctrl;
	enclave_page_augment_pkg::dest_state_t dest;
	enclave_page_augment_pkg::env_t env;
	enclave_page_augment_pkg::fault_t fault;
	enclave_page_augment_pkg::exit_info_t ex;
	enclave_page_augment_pkg::map_entry_t entry, me;
	logic busy, refused, done, mem_we, map_we, ready;
	int errors = 0;
	int checks = 0;
	int maps = 0;
	int wcount, nz, w0;
	int unsigned codes[17] = '{1, 1, 2, 1, 1, 3, 1, 4, 2, 1, 1, 1, 3, 1, 1, 1, 1};
	always #2 clk_sys = ~clk_sys;
	enclave_page_augment enclave_page_augment_inst (.i_clk_sys(clk_sys), .i_rst_n(rst_n),
		.i_start(start), .i_leaf_select(leaf), .i_desc_ptr(desc_ptr), .i_dest_ptr(dest_ptr),
		.i_desc(desc), .i_sec(sec), .i_ctrl(ctrl), .i_dest(dest), .i_env(env), .o_busy(busy),
		.o_refused(refused), .o_done(done), .o_fault(fault), .o_pf_addr(pf), .o_exit(ex),
		.i_mem_ready(ready), .o_mem_we(mem_we), .o_mem_addr(mem_addr), .o_mem_data(mem_data),
		.o_map_we(map_we), .o_map_addr(map_addr), .o_map_entry(entry));
	augment_mem_model augment_mem_model_inst (.i_clk_sys(clk_sys), .i_rst_n(rst_n),
		.i_slow(slow), .i_we(mem_we), .i_addr(mem_addr), .i_data(mem_data), .o_ready(ready),
		.o_count(wcount), .o_nz(nz), .o_last(last), .o_last_addr(last_addr));
	// Keep the last map write, which must be the one that sets valid
	always @(posedge clk_sys) if (map_we) begin
		me <= entry;
		maps <= maps + 1;
	end
	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic end_of_test();
		if (errors == 0 && checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
		checks++;
		if (g !== e) begin
			errors++;
			$display("unexpected %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic chk_m(input enclave_page_augment_pkg::map_entry_t e);
		checks++;
		if (me !== e) begin
			errors++;
			$display("unexpected map entry expected %h seen %h", e, me);
		end
	endtask
	// Legal request for a supplied shadow-stack first page
	task automatic good();
		desc_ptr = 64'h1000;
		dest_ptr = 64'h20000;
		desc = '{64'h0, 64'h3000, 64'h8000, 64'h50000};
		sec = '{enclave_page_augment_pkg::SHADOW_STACK_FIRST_TYPE, 1'b1, 1'b1, 1'b0, 1'b0};
		ctrl = '{1'b1, 1'b0, 1'b1, enclave_page_augment_pkg::CONTROL_PAGE_TYPE, 1'b1,
			64'h40000, 64'h40000, 1'b1, 64'h77};
		dest = '{1'b1, 1'b0, 1'b0, 64'h9000};
		env = '{2'h0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
	endtask
	// Inputs stay held until done, since the check cycle samples them
	task automatic run(input logic [63:0] f);
		w0 = wcount;
		@(negedge clk_sys) start = 1'b1;
		@(negedge clk_sys) start = 1'b0;
		for (int i = 0; i < 3000 && done !== 1'b1; i++) @(negedge clk_sys);
		if (done !== 1'b1) begin
			errors++;
			end_of_test();
		end
		chk("fault", f, 64'(fault));
		if (f != 0) chk("writes", 0, 64'(wcount - w0));
	endtask
	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_default();
		good();
		desc.sec_info = 64'h0;
		run(0);
		chk("words", 512, 64'(wcount - w0));
		chk("nonzero", 0, 64'(nz));
		chk("map writes", 2, 64'(maps));
		chk("map addr", 64'h20000, map_addr);
		chk_m('{1'b1, 1'b1, 1'b0, enclave_page_augment_pkg::REGULAR_PAGE_TYPE, 64'h50000,
			1'b0, 1'b1, 1'b0, 1'b0, 64'h77, 1'b1});
	endtask
	task automatic t_token();
		good();
		slow = 1'b1;
		run(0);
		slow = 1'b0;
		chk("words", 513, 64'(wcount - w0));
		chk("token", 64'h51001, last);
		chk("token addr", 64'h20ff8, last_addr);
		chk_m('{1'b1, 1'b1, 1'b0, enclave_page_augment_pkg::SHADOW_STACK_FIRST_TYPE, 64'h50000,
			1'b0, 1'b1, 1'b0, 1'b0, 64'h77, 1'b1});
	endtask
	// One broken operand per pass, in check order except the last pass (unaligned control page)
	task automatic t_faults();
		for (int i = 0; i < 17; i++) begin
			good();
			case (i)
				0: desc_ptr = 64'h1010;
				1: dest_ptr = 64'h20008;
				2: dest.resolves = 1'b0;
				3: desc.sec_info = 64'h8020;
				4: desc.source_page_pointer = 64'h1000;
				5: ctrl.resolves = 1'b0;
				6: dest.excl_busy = 1'b1;
				7: dest = '{1'b1, 1'b1, 1'b0, 64'h9000};
				8: dest.map_valid = 1'b1;
				9: sec.x = 1'b1;
				10: env.control_flow_enforce_enable = 1'b0;
				11: ctrl.shared_busy = 1'b1;
				12: ctrl.map_type = enclave_page_augment_pkg::REGULAR_PAGE_TYPE;
				13: ctrl.initialized = 1'b0;
				14: desc.target_linear_address = 64'h80000;
				15: desc.target_linear_address = 64'h40000;
				default: desc.ctrl_page = 64'h3800;
			endcase
			if (i == 7) env = '{2'h0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1};
			run(64'(codes[i]));
			if (codes[i] == 2) chk("pf addr", 64'h20000, pf);
			if (codes[i] == 3) chk("pf addr", 64'h3000, pf);
			if (i == 7) chk("exit lin", 64'h20000, ex.guest_lin);
		end
	endtask
	task automatic t_refused();
		good();
		env.cpl = 2'h3;
		@(negedge clk_sys) start = 1'b1;
		@(negedge clk_sys) start = 1'b0;
		chk("refused", 1, 64'(refused));
		good();
		leaf = 32'h0000000c;
		@(negedge clk_sys) start = 1'b1;
		@(negedge clk_sys) start = 1'b0;
		chk("busy", 0, 64'(busy));
		leaf = 32'h0000000d;
	endtask
	initial begin
		good();
		repeat (6) @(negedge clk_sys);
		rst_n = 1'b1;
		t_default();
		t_token();
		t_faults();
		t_refused();
		end_of_test();
	end
endmodule
